// ### sli_pkg.sv
// Constants shared by the serial link interrupt status block and its per-link bank.
// Assumes an 8-bit register port with 12-bit addresses and two banked links.
package sli_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_LINKS    = 2;
  localparam int LINK_W       = 1;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 8;
  localparam int CFG_BYTES    = 14;
  localparam int CFG_IDX_W    = 4;
  localparam logic [CFG_IDX_W-1:0] CFG_LAST_IDX = 4'hD;

  // ==========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE = 12'h300;
  localparam logic [ADDR_W-1:0] ADDR_CFG_FIRST = 12'h450;
  localparam logic [ADDR_W-1:0] ADDR_CFG_LAST  = 12'h45D;
  localparam logic [ADDR_W-1:0] ADDR_EN_A      = 12'h4B8;
  localparam logic [ADDR_W-1:0] ADDR_EN_B      = 12'h4B9;
  localparam logic [ADDR_W-1:0] ADDR_STAT_A    = 12'h4BA;
  localparam logic [ADDR_W-1:0] ADDR_STAT_B    = 12'h4BB;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE     = 12'h4BC;

  // ==========================================================================
  // Field layout and reset values
  localparam int BIT_BAD_DISPARITY  = 7;
  localparam int BIT_NOT_IN_TABLE   = 6;
  localparam int BIT_UNEXPECTED_K   = 5;
  localparam int BIT_LANE_DESKEW    = 4;
  localparam int BIT_INIT_LANE_SYNC = 3;
  localparam int BIT_CHECKSUM_GOOD  = 2;
  localparam int BIT_FRAME_SYNC     = 1;
  localparam int BIT_CODE_GRP_SYNC  = 0;
  localparam int BIT_CFG_MISMATCH   = 0;
  localparam int BIT_PIN_SELECT     = 0;
  localparam int BIT_LINK_PAGE      = 0;

  localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] MASK_B     = 8'h01;
  localparam logic [DATA_W-1:0] MASK_ROUTE = 8'h01;
  localparam logic [DATA_W-1:0] MASK_PAGE  = 8'h01;

endpackage

// ### sli_link_bank.sv
// One link's copy of the event enables, sticky event status and expected lane-0 configuration.
// Assumes the top decodes the link page and presents register writes with bankSel.
`timescale 1ns/10ps

module sli_link_bank
  import sli_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              bankSel,
  input  wire logic              regWrEn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic [DATA_W-1:0] eventPulse,
  input  wire logic              lane0IlasValid,
  input  wire logic [CFG_IDX_W-1:0] lane0IlasIndex,
  input  wire logic [DATA_W-1:0] lane0IlasByte,
  output logic      [DATA_W-1:0] enableA,
  output logic      [DATA_W-1:0] enableB,
  output logic      [DATA_W-1:0] statusA,
  output logic      [DATA_W-1:0] statusB,
  output logic      [DATA_W-1:0] cfgRdByte,
  output logic                   irqReq
);

  // ==========================================================================
  // Decode
  logic [DATA_W-1:0]    enableA_r, enableB_r, statusA_r, statusB_r;
  logic [DATA_W-1:0]    statusA_nxt, statusB_nxt;
  logic [DATA_W-1:0]    cfgExp_r [CFG_BYTES];
  logic                 wrHit, wrEnA, wrEnB, wrStatA, wrStatB, wrCfg, inCfg;
  logic [CFG_IDX_W-1:0] cfgIdx;
  logic                 ilasIdxOk, mismatch;
  logic [DATA_W-1:0]    cfgAtIlas, clrA, clrB;

  assign wrHit   = regWrEn & bankSel;
  assign wrEnA   = wrHit && (regAddr == ADDR_EN_A);
  assign wrEnB   = wrHit && (regAddr == ADDR_EN_B);
  assign wrStatA = wrHit && (regAddr == ADDR_STAT_A);
  assign wrStatB = wrHit && (regAddr == ADDR_STAT_B);
  assign inCfg   = (regAddr >= ADDR_CFG_FIRST) && (regAddr <= ADDR_CFG_LAST);
  assign wrCfg   = wrHit && inCfg;
  assign cfgIdx  = CFG_IDX_W'(regAddr - ADDR_CFG_FIRST);

  // ==========================================================================
  // Expected configuration and lane-0 comparison
  genvar g;
  generate
    for (g = 0; g < CFG_BYTES; g++) begin : gCfg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cfgExp_r[g] <= REG_RESET;
        end else if (wrCfg && (cfgIdx == CFG_IDX_W'(g))) begin
          cfgExp_r[g] <= regWrData;
        end
      end
    end
  endgenerate

  assign cfgRdByte = inCfg ? cfgExp_r[cfgIdx] : REG_RESET;

  assign ilasIdxOk = lane0IlasIndex <= CFG_LAST_IDX;
  assign cfgAtIlas = ilasIdxOk ? cfgExp_r[lane0IlasIndex] : lane0IlasByte;
  assign mismatch  = lane0IlasValid && ilasIdxOk && (lane0IlasByte != cfgAtIlas);

  // ==========================================================================
  // Sticky status, write one to clear; a new event beats a clear.
  assign clrA = wrStatA ? regWrData : REG_RESET;
  assign clrB = wrStatB ? regWrData : REG_RESET;

  assign statusA_nxt = (statusA_r & ~clrA) | eventPulse;
  assign statusB_nxt = ((statusB_r & ~clrB) | (DATA_W'(mismatch) << BIT_CFG_MISMATCH)) & MASK_B;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enableA_r <= REG_RESET;
      enableB_r <= REG_RESET;
      statusA_r <= REG_RESET;
      statusB_r <= REG_RESET;
    end else begin
      if (wrEnA) begin
        enableA_r <= regWrData;
      end
      if (wrEnB) begin
        enableB_r <= regWrData & MASK_B;
      end
      statusA_r <= statusA_nxt;
      statusB_r <= statusB_nxt;
    end
  end

  assign enableA = enableA_r;
  assign enableB = enableB_r;
  assign statusA = statusA_r;
  assign statusB = statusB_r;
  assign irqReq  = (|(statusA_r & enableA_r)) | (|(statusB_r & enableB_r));

endmodule // sli_link_bank

// ### sli_irq_status.sv
// Serial link receiver interrupt status: link page, banked event registers, pin routing.
// Assumes an 8-bit register port synchronous to clk and one-cycle event pulses per link.
`timescale 1ns/10ps

module sli_irq_status
  import sli_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [ADDR_W-1:0]             regAddr,
  input  wire logic [DATA_W-1:0]             regWrData,
  input  wire logic                          regWrEn,
  input  wire logic                          regRdEn,
  output logic      [DATA_W-1:0]             regRdData,
  output logic                               regRdValid,
  input  wire logic [NUM_LINKS*DATA_W-1:0]   eventPulse,
  input  wire logic [NUM_LINKS-1:0]          lane0IlasValid,
  input  wire logic [NUM_LINKS*CFG_IDX_W-1:0] lane0IlasIndex,
  input  wire logic [NUM_LINKS*DATA_W-1:0]   lane0IlasByte,
  output logic                               irqPin0,
  output logic                               irqPin1
);

  // ==========================================================================
  // Global registers
  logic [DATA_W-1:0] linkPage_r, route_r, rdData_r, rdData_nxt;
  logic              rdValid_r, irqPin0_r, irqPin1_r;
  logic [LINK_W-1:0] pageIdx;
  logic              wrPage, wrRoute, irqAny, pinSel;

  assign wrPage  = regWrEn && (regAddr == ADDR_LINK_PAGE);
  assign wrRoute = regWrEn && (regAddr == ADDR_ROUTE);
  assign pageIdx = linkPage_r[BIT_LINK_PAGE +: LINK_W];
  assign pinSel  = route_r[BIT_PIN_SELECT];

  // ==========================================================================
  // Link banks
  logic [DATA_W-1:0]    bankEnA   [NUM_LINKS];
  logic [DATA_W-1:0]    bankEnB   [NUM_LINKS];
  logic [DATA_W-1:0]    bankStatA [NUM_LINKS];
  logic [DATA_W-1:0]    bankStatB [NUM_LINKS];
  logic [DATA_W-1:0]    bankCfg   [NUM_LINKS];
  logic [NUM_LINKS-1:0] bankIrq;

  genvar l;
  generate
    for (l = 0; l < NUM_LINKS; l++) begin : gLink
      sli_link_bank uBank (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .bankSel        (pageIdx == LINK_W'(l)),
        .regWrEn        (regWrEn),
        .regAddr        (regAddr),
        .regWrData      (regWrData),
        .eventPulse     (eventPulse[l*DATA_W +: DATA_W]),
        .lane0IlasValid (lane0IlasValid[l]),
        .lane0IlasIndex (lane0IlasIndex[l*CFG_IDX_W +: CFG_IDX_W]),
        .lane0IlasByte  (lane0IlasByte[l*DATA_W +: DATA_W]),
        .enableA        (bankEnA[l]),
        .enableB        (bankEnB[l]),
        .statusA        (bankStatA[l]),
        .statusB        (bankStatB[l]),
        .cfgRdByte      (bankCfg[l]),
        .irqReq         (bankIrq[l])
      );
    end
  endgenerate

  // ==========================================================================
  // Read path; unmapped addresses read as zero.
  logic inCfg;
  assign inCfg = (regAddr >= ADDR_CFG_FIRST) && (regAddr <= ADDR_CFG_LAST);

  assign rdData_nxt = (regAddr == ADDR_LINK_PAGE) ? linkPage_r :
                      (regAddr == ADDR_ROUTE)     ? route_r :
                      (regAddr == ADDR_EN_A)      ? bankEnA[pageIdx] :
                      (regAddr == ADDR_EN_B)      ? bankEnB[pageIdx] :
                      (regAddr == ADDR_STAT_A)    ? bankStatA[pageIdx] :
                      (regAddr == ADDR_STAT_B)    ? bankStatB[pageIdx] :
                      inCfg                       ? bankCfg[pageIdx] :
                                                    REG_RESET;

  // Every link feeds the request, not only the paged one, so a paged-away link is never masked.
  assign irqAny = |bankIrq;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linkPage_r <= REG_RESET;
      route_r    <= REG_RESET;
      rdData_r   <= REG_RESET;
      rdValid_r  <= 1'b0;
      irqPin0_r  <= 1'b0;
      irqPin1_r  <= 1'b0;
    end else begin
      if (wrPage) begin
        linkPage_r <= regWrData & MASK_PAGE;
      end
      if (wrRoute) begin
        route_r <= regWrData & MASK_ROUTE;
      end
      rdValid_r <= regRdEn;
      if (regRdEn) begin
        rdData_r <= rdData_nxt;
      end
      irqPin0_r <= irqAny & ~pinSel;
      irqPin1_r <= irqAny & pinSel;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;
  assign irqPin0    = irqPin0_r;
  assign irqPin1    = irqPin1_r;

endmodule // sli_irq_status

// ### sli_irq_status_properties.sv
// Checker for the serial link interrupt status block, bound to its top module.
// Assumes the one-cycle read latency and registered pins of the register port.
`timescale 1ns/10ps

module sli_irq_status_properties
  import sli_pkg::*;
(
  input wire logic                           clk,
  input wire logic                           sys_rst,
  input wire logic [ADDR_W-1:0]              regAddr,
  input wire logic                           regWrEn,
  input wire logic                           regRdEn,
  input wire logic [DATA_W-1:0]              regRdData,
  input wire logic                           regRdValid,
  input wire logic                           irqPin0,
  input wire logic                           irqPin1
);
  // ==========
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_read_answered: assert property (regRdEn |=> regRdValid)
    else $error("read strobe not answered");
  chk_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("read valid without a read");
  chk_data_holds: assert property (!regRdValid |-> $stable(regRdData))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (regRdEn && regAddr == 12'h123 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_statb_reserved: assert property (regRdEn && regAddr == ADDR_STAT_B |=> regRdData[7:1] == 7'h00)
    else $error("status B reserved bits set");
  chk_route_reserved: assert property (regRdEn && regAddr == ADDR_ROUTE |=> regRdData[7:1] == 7'h00)
    else $error("route reserved bits set");
  chk_pins_exclusive: assert property (!(irqPin0 && irqPin1))
    else $error("both interrupt pins high");
  chk_pin_fall_cause: assert property ($fell(irqPin0) || $fell(irqPin1) |-> $past(regWrEn) || $past(regWrEn, 2))
    else $error("interrupt pin fell without a write");
endmodule // sli_irq_status_properties

bind sli_irq_status sli_irq_status_properties chk_i (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
  .irqPin0(irqPin0), .irqPin1(irqPin1));

// ### sli_link_src.sv
// Far-side model: link receiver event pulses and lane-0 configuration bytes.
// Assumes the bench calls its tasks from one sequence on the same clock.
`timescale 1ns/10ps

module sli_link_src
  import sli_pkg::*;
(
  input  wire logic                           clk,
  output logic [NUM_LINKS*DATA_W-1:0]         evt,
  output logic [NUM_LINKS-1:0]                vld,
  output logic [NUM_LINKS*CFG_IDX_W-1:0]      idx,
  output logic [NUM_LINKS*DATA_W-1:0]         dat
);
  // ==========
  // Stimulus tasks
  initial begin
    evt = '0;
    vld = '0;
    idx = '0;
    dat = '0;
  end

  task automatic pulse(input int l, input logic [DATA_W-1:0] e);
    @(posedge clk);
    evt[l*DATA_W+:DATA_W] <= e;
    @(posedge clk);
    evt <= '0;
  endtask

  // Released lines show the inverse, so a stale byte can never pass as fresh.
  task automatic ilas(input int l, input logic [CFG_IDX_W-1:0] i, input logic [DATA_W-1:0] b);
    @(posedge clk);
    vld[l] <= 1'h1;
    idx[l*CFG_IDX_W+:CFG_IDX_W] <= i;
    dat[l*DATA_W+:DATA_W] <= b;
    @(posedge clk);
    vld <= '0;
    idx[l*CFG_IDX_W+:CFG_IDX_W] <= ~i;
    dat[l*DATA_W+:DATA_W] <= ~b;
  endtask
endmodule // sli_link_src

// ### sli_irq_status_tb.sv
// Self-checking bench for the serial link interrupt status block.
// Assumes the link source model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module sli_irq_status_tb;
  import sli_pkg::*;
  logic                       clk = 1'h0;
  logic                       sysRst = 1'h1;
  logic [ADDR_W-1:0]          regAddr = '0;
  logic [DATA_W-1:0]          regWrData = '0;
  logic                       regWrEn = 1'h0;
  logic                       regRdEn = 1'h0;
  logic [DATA_W-1:0]          regRdData;
  logic                       regRdValid;
  logic                       irqPin0;
  logic                       irqPin1;
  logic [NUM_LINKS*DATA_W-1:0] evt;
  logic [NUM_LINKS-1:0]       vld;
  logic [7:0]                 idx;
  logic [NUM_LINKS*DATA_W-1:0] dat;
  int                         errTotal = 0;
  int                         totalChecks = 0;

  always #12.5 clk = ~clk;

  sli_irq_status uut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .eventPulse(evt), .lane0IlasValid(vld), .lane0IlasIndex(idx), .lane0IlasByte(dat),
    .irqPin0(irqPin0), .irqPin1(irqPin1));
  sli_link_src src (.clk(clk), .evt(evt), .vld(vld), .idx(idx), .dat(dat));

  // ==========
  // Bus and compare tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge clk);
    regWrEn <= 1'h0;
  endtask

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge clk);
    regRdEn <= 1'h0;
    // Valid stands for the single cycle after the strobe edge, so look right after that edge.
    #1;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, exp);
  endtask

  task automatic pins(input logic [1:0] exp);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h00, irqPin1, irqPin0}, {6'h00, exp});
  endtask

  // ==========
  // Scenarios
  task automatic tResetValues;
    logic [ADDR_W-1:0] a [8] = '{ADDR_LINK_PAGE, ADDR_CFG_FIRST, ADDR_EN_A, ADDR_EN_B,
                                 ADDR_STAT_A, ADDR_STAT_B, ADDR_ROUTE, 12'h123};
    foreach (a[i]) rdChk(a[i], 8'h00);
  endtask

  task automatic tEvents;
    wr(ADDR_EN_A, 8'hFF);
    src.pulse(0, 8'hA5);
    rdChk(ADDR_STAT_A, 8'hA5);
    pins(2'h1);
    src.pulse(0, 8'h5A);
    rdChk(ADDR_STAT_A, 8'hFF);
    wr(ADDR_STAT_A, 8'h0F);
    rdChk(ADDR_STAT_A, 8'hF0);
    wr(ADDR_EN_A, 8'h0F);
    pins(2'h0);
  endtask

  task automatic tBanking;
    wr(ADDR_LINK_PAGE, 8'hFF);
    rdChk(ADDR_LINK_PAGE, 8'h01);
    rdChk(ADDR_STAT_A, 8'h00);
    src.pulse(1, 8'h81);
    rdChk(ADDR_STAT_A, 8'h81);
    wr(ADDR_LINK_PAGE, 8'h00);
    rdChk(ADDR_STAT_A, 8'hF0);
    wr(ADDR_STAT_A, 8'hFF);
  endtask

  task automatic tRoute;
    wr(ADDR_EN_A, 8'h80);
    src.pulse(0, 8'h80);
    wr(ADDR_ROUTE, 8'hFF);
    rdChk(ADDR_ROUTE, 8'h01);
    pins(2'h2);
    wr(ADDR_ROUTE, 8'h00);
    pins(2'h1);
    wr(ADDR_STAT_A, 8'h80);
    pins(2'h0);
  endtask

  task automatic tMismatch;
    wr(ADDR_CFG_LAST, 8'h3C);
    src.ilas(0, 4'hD, 8'h3C);
    rdChk(ADDR_STAT_B, 8'h00);
    src.ilas(0, 4'hD, 8'h3D);
    rdChk(ADDR_STAT_B, 8'h01);
    wr(ADDR_EN_B, 8'hFF);
    rdChk(ADDR_EN_B, 8'h01);
    pins(2'h1);
    wr(ADDR_STAT_B, 8'h01);
    rdChk(ADDR_STAT_B, 8'h00);
  endtask

  task automatic tMismatchLink;
    wr(ADDR_LINK_PAGE, 8'h01);
    wr(ADDR_CFG_FIRST, 8'h11);
    src.ilas(1, 4'h0, 8'h11);
    src.ilas(1, 4'hE, 8'h55);
    rdChk(ADDR_STAT_B, 8'h00);
    src.ilas(1, 4'h0, 8'h12);
    rdChk(ADDR_STAT_B, 8'h01);
    wr(ADDR_LINK_PAGE, 8'h00);
    rdChk(ADDR_STAT_B, 8'h00);
    rdChk(ADDR_CFG_FIRST, 8'h00);
    wr(ADDR_LINK_PAGE, 8'h01);
    wr(ADDR_STAT_B, 8'h01);
    rdChk(ADDR_STAT_B, 8'h00);
    wr(ADDR_LINK_PAGE, 8'h00);
  endtask

  // An event arriving in the same cycle as its clear must leave the bit set.
  task automatic tSetWins;
    fork
      wr(ADDR_STAT_A, 8'h01);
      src.pulse(0, 8'h01);
    join
    rdChk(ADDR_STAT_A, 8'h01);
    wr(ADDR_STAT_A, 8'h01);
    rdChk(ADDR_STAT_A, 8'h00);
  endtask

  task automatic tMidReset;
    src.pulse(0, 8'h80);
    pins(2'h1);
    @(posedge clk);
    sysRst <= 1'h1;
    repeat (2) @(posedge clk);
    sysRst <= 1'h0;
    pins(2'h0);
    rdChk(ADDR_EN_A, 8'h00);
    rdChk(ADDR_STAT_A, 8'h00);
  endtask

  // ==========
  // Verdict and sequence
  task automatic giveVerdict;
    $display("checks=%0d errors=%0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The whole run needs well under 1000 cycles; the limit leaves ample slack.
  initial begin
    #50us;
    errTotal++;
    giveVerdict;
  end

  initial begin
    repeat (8) @(posedge clk);
    sysRst <= 1'h0;
    tResetValues;
    tEvents;
    tBanking;
    tRoute;
    tMismatch;
    tMismatchLink;
    tSetWins;
    tMidReset;
    giveVerdict;
  end
endmodule // sli_irq_status_tb
